// ===== test/ptm_memory_map_properties.sv
// Assertions on ptm_memory_map ports.
// Assumes the bind at the foot reaches every instance.
`timescale 1ns/10ps
`include "ptm_cfg.svh"

module ptm_memory_map_properties #(
    parameter int PM_AW = 13
) (
    input wire logic               ref_clk,              // Clock
    input wire logic               rst,                  // Reset
    input wire logic               regRd,                // Read strobe
    input wire ptm_pkg::ptm_byte_t regRdData,            // Read data
    input wire logic               readTableCurrentPage, // Table read
    input wire logic               readTableLastPage,    // Table read
    input wire ptm_pkg::ptm_pc_t   fetchAddr,            // Fetch address
    input wire logic               fetchValid,           // Fetch valid
    input wire logic               tableBusy,            // Table busy
    input wire ptm_pkg::ptm_byte_t tableHighByte,        // High byte
    input wire logic               vectorTaken           // Vector entry
);
    import ptm_pkg::*;
    wire logic tblReq;
    assign tblReq = (readTableCurrentPage || readTableLastPage) && !tableBusy;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    table_two_cycles_a: assert property (tblReq |=> tableBusy ##1 !tableBusy)
        else $error("table read length wrong");
    busy_has_cause_a: assert property (tableBusy |-> $past(tblReq))
        else $error("busy without request");
    fetch_suspended_a: assert property (tableBusy |=> !fetchValid)
        else $error("fetch during table cycle");
    last_page_a: assert property (tblReq && readTableLastPage |=> ##1 fetchAddr[PM_AW-1:8] == '1)
        else $error("last page address wrong");
    high_byte_kept_a: assert property (!tableBusy |=> $stable(tableHighByte))
        else $error("high byte changed");
    vector_entry_a: assert property (vectorTaken |-> !fetchValid ##1
        fetchAddr inside {`PTM_EXT_VEC, `PTM_TMR0_VEC, `PTM_TMR1_VEC, `PTM_TMR2_VEC, `PTM_TB_VEC})
        else $error("vector entry wrong");
    vector_pulse_a: assert property (vectorTaken |=> !vectorTaken)
        else $error("vector pulse too long");
    reset_vector_a: assert property ($fell(rst) |=> fetchValid && fetchAddr == `PTM_RESET_VEC)
        else $error("no fetch at reset vector");
    read_slot_a: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data outside slot");
    cover property (tblReq && readTableLastPage);
    cover property (tblReq && readTableCurrentPage);
    cover property (vectorTaken);
    cover property (regRd ##1 regRdData != 8'h00);
endmodule : ptm_memory_map_properties

bind ptm_memory_map ptm_memory_map_properties #(.PM_AW(PM_AW)) ptm_memory_map_properties_inst (
    .ref_clk, .rst, .regRd, .regRdData, .readTableCurrentPage, .readTableLastPage,
    .fetchAddr, .fetchValid, .tableBusy, .tableHighByte, .vectorTaken
);

// ===== test/ptm_memory_map_tb.sv
// Self-checking bench for ptm_memory_map.
// Assumes the design and its bound checker are compiled first.
`timescale 1ns/10ps
`include "ptm_cfg.svh"

module ptm_memory_map_tb;
    import ptm_pkg::*;
    localparam int DW = 14;
    localparam ptm_byte_t HMASK = 8'((1 << (DW - 8)) - 1);
    localparam logic [14:0] S_WR = 15'h4000, S_RD = 15'h2000, S_SET = 15'h1000, S_CLR = 15'h0800;
    localparam logic [14:0] S_TCP = 15'h0400, S_TLP = 15'h0200, S_JMP = 15'h0100, S_CALL = 15'h0080;
    localparam logic [14:0] S_RET = 15'h0040, S_RETI = 15'h0020, S_PROG = 15'h0010, S_TB = 15'h0008;
    typedef struct packed {ptm_byte_t a; ptm_byte_t d; logic ub; ptm_byte_t e;} ptm_row_t;
    logic ref_clk, rst, regUseBank, extIntPin, fetchValid, tableBusy, vectorTaken, hit;
    logic [14:0] stb;
    logic [2:0] bitSel;
    wire logic regWr, regRd, bitSet, bitClr, readTableCurrentPage, readTableLastPage;
    wire logic cmdJump, cmdCall, cmdReturn, cmdRetInt, progWr, timeBaseOvf;
    wire logic [2:0] timerOvf;
    ptm_byte_t regAddr, regWrData, tblDest, regRdData, tableHighByte;
    ptm_pc_t cmdAddr, progAddr, fetchAddr;
    ptm_word_t progData, fetchWord;
    int mismatches, num_checks;
    ptm_row_t rows [10];
    ptm_pc_t vecs [4];
    logic [1:0] edges [3];

    // One vector holds every strobe so a single clear ends them all
    assign {regWr, regRd, bitSet, bitClr, readTableCurrentPage, readTableLastPage, cmdJump, cmdCall,
            cmdReturn, cmdRetInt, progWr, timeBaseOvf, timerOvf} = stb;

    ptm_memory_map #(.PM_DW(DW)) ptm_memory_map_inst (
        .ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regUseBank, .bitSet, .bitClr, .bitSel,
        .regRdData, .readTableCurrentPage, .readTableLastPage, .tblDest, .cmdJump, .cmdCall, .cmdReturn,
        .cmdRetInt, .cmdAddr, .extIntPin, .timerOvf, .timeBaseOvf, .progWr, .progAddr, .progData,
        .fetchAddr, .fetchWord, .fetchValid, .tableBusy, .tableHighByte, .vectorTaken
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: check %0d got %h want %h", $time, num_checks, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic go(input logic [14:0] s);
        @(posedge ref_clk);
        stb <= s;
        @(posedge ref_clk);
        stb <= '0;
    endtask : go

    task automatic wr(input ptm_byte_t a, input ptm_byte_t d, input logic ub);
        regAddr <= a;
        regWrData <= d;
        regUseBank <= ub;
        go(S_WR);
    endtask : wr

    task automatic rd(input ptm_byte_t a, input logic ub, input ptm_byte_t e);
        regAddr <= a;
        regUseBank <= ub;
        go(S_RD);
        #1;
        chk(regRdData, e);
    endtask : rd

    // Fixed window covers sync, edge and entry latency
    task automatic wait_vec(input logic want, input ptm_pc_t v);
        int n;
        n = 0;
        #1;
        while (vectorTaken !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(vectorTaken, want);
        if (want && n == 10) begin
            final_report();
        end
        if (want) begin
            @(posedge ref_clk);
            #1;
            chk(fetchAddr, v);
        end
    endtask : wait_vec

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(fetchAddr, `PTM_RESET_VEC);
        chk(tableHighByte, 8'h00);
    endtask : do_reset

    initial begin
        rst = 1'b1;
        stb = '0;
        regUseBank = 1'b0;
        extIntPin = 1'b0;
        bitSel = 3'h0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        tblDest = 8'h00;
        cmdAddr = 13'h0000;
        progAddr = 13'h0000;
        progData = 16'h0000;
        mismatches = 0;
        num_checks = 0;
        rows = '{'{8'h20, 8'ha5, 1'b0, 8'ha5}, '{8'h21, 8'h5a, 1'b0, 8'h5a}, '{8'h01, 8'hff, 1'b0, 8'h00},
                 '{8'h05, 8'hff, 1'b0, 8'h00}, '{8'h06, 8'h33, 1'b0, 8'h00}, '{8'h1f, 8'h44, 1'b0, 8'h00},
                 '{8'h00, 8'h06, 1'b0, 8'h06}, '{8'h02, 8'hff, 1'b0, 8'h01}, '{8'h20, 8'h77, 1'b1, 8'h77},
                 '{8'ha0, 8'h99, 1'b1, 8'h00}};
        vecs = '{`PTM_TMR0_VEC, `PTM_TMR1_VEC, `PTM_TMR2_VEC, `PTM_TB_VEC};
        edges = '{`PTM_EDGE_RISE, `PTM_EDGE_FALL, `PTM_EDGE_BOTH};
        do_reset();
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].ub);
            rd(rows[i].a, rows[i].ub, rows[i].e);
        end
        $display("register rows done");
        rd(8'h20, 1'b0, 8'ha5);
        wr(`PTM_SFR_BANK, 8'h00, 1'b0);
        rd(8'h20, 1'b1, 8'ha5);
        regUseBank <= 1'b0;
        regAddr <= 8'h21;
        go(S_SET);
        bitSel <= 3'h6;
        go(S_CLR);
        rd(8'h21, 1'b0, 8'h1b);
        $display("bank and bit tests done");
        progAddr <= 13'h1f06;
        progData <= 16'hbe1a;
        go(S_PROG);
        progAddr <= 13'h0506;
        progData <= 16'h3c4d;
        go(S_PROG);
        tblDest <= 8'h22;
        go(S_TLP);
        #1;
        chk(tableBusy, 1'b1);
        @(posedge ref_clk);
        #1;
        chk(tableBusy, 1'b0);
        chk(fetchAddr, 13'h1f06);
        chk(fetchValid, 1'b0);
        chk(tableHighByte, 8'hbe & HMASK);
        rd(8'h22, 1'b0, 8'h1a);
        cmdAddr <= 13'h0500;
        go(S_JMP);
        tblDest <= 8'h23;
        go(S_TCP);
        @(posedge ref_clk);
        #1;
        chk(fetchAddr, 13'h0506);
        wr(`PTM_SFR_TABLE_HIGH_BYTE, 8'h00, 1'b0);
        #1;
        chk(tableHighByte, 8'h3c & HMASK);
        rd(8'h23, 1'b0, 8'h4d);
        cmdAddr <= 13'h0506;
        go(S_JMP);
        @(posedge ref_clk);
        #1;
        chk(fetchWord, 16'h3c4d);
        chk(fetchValid, 1'b1);
        $display("table read tests done");
        wr(`PTM_SFR_INTEN, 8'h03, 1'b0);
        foreach (edges[c]) begin
            wr(`PTM_SFR_EDGE, 8'(edges[c]), 1'b0);
            for (int p = 1; p >= 0; p--) begin
                hit = (c == 2) || ((p == 1) == (c == 0));
                extIntPin <= p[0];
                wait_vec(hit, `PTM_EXT_VEC);
                if (hit) begin
                    go(S_RETI);
                end
            end
        end
        for (int s = 0; s < 4; s++) begin
            wr(`PTM_SFR_INTEN, 8'h01 | (8'h04 << s), 1'b0);
            go(s < 3 ? 15'(1 << s) : S_TB);
            wait_vec(1'b1, vecs[s]);
            go(S_RETI);
        end
        cmdAddr <= 13'h0600;
        repeat (8) go(S_CALL);
        wr(`PTM_SFR_INTEN, 8'h05, 1'b0);
        go(15'h0001);
        wait_vec(1'b0, `PTM_TMR0_VEC);
        go(S_RET);
        wait_vec(1'b1, `PTM_TMR0_VEC);
        wr(`PTM_SFR_INTEN, 8'h01, 1'b0);
        go(S_TB);
        wait_vec(1'b0, `PTM_TB_VEC);
        $display("interrupt tests done");
        do_reset();
        $display("second reset done");
        final_report();
    end
endmodule : ptm_memory_map_tb

// ===== verilog/ptm_cfg.svh
// Constants of the program table and memory map block.
// Assumes inclusion by ptm_memory_map, its bound checker and its bench.
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH

`define PTM_RESET_VEC    13'h0000
`define PTM_EXT_VEC      13'h0004
`define PTM_TMR0_VEC     13'h0008
`define PTM_TMR1_VEC     13'h000c
`define PTM_TMR2_VEC     13'h0010
`define PTM_TB_VEC       13'h0014

`define PTM_SFR_TBLP     8'h00
`define PTM_SFR_TABLE_HIGH_BYTE     8'h01
`define PTM_SFR_BANK     8'h02
`define PTM_SFR_EDGE     8'h03
`define PTM_SFR_INTEN    8'h04
`define PTM_SFR_PEND     8'h05
`define PTM_GP_START     8'h20
`define PTM_BANK1_BASE   9'h100

`define PTM_EDGE_RISE    2'h1
`define PTM_EDGE_FALL    2'h2
`define PTM_EDGE_BOTH    2'h3

`define PTM_INTEN_GLOBAL 0
`define PTM_LAST_PAGE    5'h1f

`endif

// ===== verilog/ptm_memory_map.sv
// Program memory, table read unit, vectors, stack and data memory map.
// Assumes a core on ref_clk drives one request per cycle and waits on tableBusy.
`timescale 1ns/10ps
`include "ptm_cfg.svh"

module ptm_memory_map #(
    parameter int PM_AW       = 13,
    parameter int PM_DW       = 16,
    parameter int DM_DEPTH    = 384,
    parameter bit BANKED      = 1'b1,
    parameter int STACK_DEPTH = 8
) (
    input  wire logic             ref_clk,       // Clock
    input  wire logic             rst,           // Sync reset, high
    input  wire ptm_pkg::ptm_byte_t regAddr,     // Data memory address
    input  wire ptm_pkg::ptm_byte_t regWrData,   // Write data
    input  wire logic             regWr,         // Write strobe
    input  wire logic             regRd,         // Read strobe
    input  wire logic             regUseBank,    // Access via second pointer
    input  wire logic             bitSet,        // Set one bit
    input  wire logic             bitClr,        // Clear one bit
    input  wire logic [2:0]       bitSel,        // Bit index
    output ptm_pkg::ptm_byte_t    regRdData,     // Read data, next cycle
    input  wire logic             readTableCurrentPage, // Table read, this page
    input  wire logic             readTableLastPage,    // Table read, last page
    input  wire ptm_pkg::ptm_byte_t tblDest,     // Destination register
    input  wire logic             cmdJump,       // Load PC
    input  wire logic             cmdCall,       // Push and load PC
    input  wire logic             cmdReturn,     // Pop PC
    input  wire logic             cmdRetInt,     // Pop PC, enable global
    input  wire ptm_pkg::ptm_pc_t cmdAddr,       // Jump or call target
    input  wire logic             extIntPin,     // External interrupt pin
    input  wire logic [2:0]       timerOvf,      // Timer overflow pulses
    input  wire logic             timeBaseOvf,   // Time base overflow pulse
    input  wire logic             progWr,        // Program memory load
    input  wire ptm_pkg::ptm_pc_t progAddr,      // Load address
    input  wire ptm_pkg::ptm_word_t progData,    // Load word
    output ptm_pkg::ptm_pc_t      fetchAddr,     // Address of fetched word
    output ptm_pkg::ptm_word_t    fetchWord,     // Fetched word
    output logic                  fetchValid,    // Fetched word is real
    output logic                  tableBusy,     // Table read second cycle
    output ptm_pkg::ptm_byte_t    tableHighByte, // Table high byte
    output logic                  vectorTaken    // Interrupt vector entered
);
    import ptm_pkg::*;

    localparam ptm_pc_t   PC_MASK = 13'((32'h1 << PM_AW) - 1);
    localparam ptm_byte_t HI_MASK = 8'((32'h1 << (PM_DW - 8)) - 1);
    localparam ptm_word_t WORD_MASK = 16'((32'h1 << PM_DW) - 1);
    localparam logic [3:0] SP_FULL = 4'(STACK_DEPTH);

    ptm_state_t s;
    ptm_state_t n;

    ptm_word_t pmem [0:(1 << PM_AW) - 1];
    ptm_byte_t dmem [0:DM_DEPTH - 1];

    logic      ramWe;
    logic [8:0] ramIdx;
    ptm_byte_t ramWd;

    // Physical RAM slot of a general purpose address
    function automatic logic [8:0] ramSlot(input ptm_byte_t a, input logic b);
        logic [8:0] r;
        r = {1'b0, a};
        if (b && BANKED) begin
            r = 9'(`PTM_BANK1_BASE + {1'b0, a} - {1'b0, `PTM_GP_START});
        end
        return r;
    endfunction : ramSlot

    function automatic logic ramOk(input logic [8:0] idx);
        return 32'(idx) < DM_DEPTH;
    endfunction : ramOk

    ptm_byte_t  src;
    ptm_byte_t  newVal;
    ptm_byte_t  wrAddr;
    logic       wrBank;
    logic       wrEn;
    logic [8:0] idx;
    logic       useB;
    logic       extEdge;
    logic [4:0] events;
    logic [4:0] live;
    logic [4:0] ackMask;
    ptm_pc_t    vec;
    ptm_word_t  tword;
    logic       tblReq;
    logic       busOp;

    always_comb begin
        n       = s;
        ramWe   = 1'b0;
        ramIdx  = 9'h000;
        ramWd   = 8'h00;
        src     = 8'h00;
        newVal  = 8'h00;
        wrAddr  = 8'h00;
        wrBank  = 1'b0;
        wrEn    = 1'b0;
        idx     = 9'h000;
        ackMask = 5'h00;
        vec     = `PTM_RESET_VEC;
        tword   = 16'h0000;
        n.vecTaken = 1'b0;
        n.rdData   = 8'h00;

        // Pin synchroniser and edge select
        n.extS1   = extIntPin;
        n.extS2   = s.extS1;
        n.extPrev = s.extS2;
        extEdge = 1'b0;
        if (s.edgeCfg == `PTM_EDGE_RISE) begin
            extEdge = s.extS2 && !s.extPrev;
        end else if (s.edgeCfg == `PTM_EDGE_FALL) begin
            extEdge = !s.extS2 && s.extPrev;
        end else if (s.edgeCfg == `PTM_EDGE_BOTH) begin
            extEdge = s.extS2 ^ s.extPrev;
        end

        events = {timeBaseOvf, timerOvf, extEdge};
        live   = s.pend & s.intEn[5:1];

        // Direct access reaches bank 0; pointer access follows bank bit
        useB  = regUseBank && s.bank;
        idx   = ramSlot(regAddr, useB);
        busOp = regWr || bitSet || bitClr;
        tblReq = readTableCurrentPage || readTableLastPage;

        // Read path, one cycle latency
        if (regRd) begin
            if (regAddr < `PTM_GP_START) begin
                if (regAddr == `PTM_SFR_TBLP) begin
                    n.rdData = s.tblp;
                end else if (regAddr == `PTM_SFR_TABLE_HIGH_BYTE) begin
                    n.rdData = s.table_high_byte;
                end else if (regAddr == `PTM_SFR_BANK) begin
                    n.rdData = {7'h00, s.bank};
                end else if (regAddr == `PTM_SFR_EDGE) begin
                    n.rdData = {6'h00, s.edgeCfg};
                end else if (regAddr == `PTM_SFR_INTEN) begin
                    n.rdData = {2'h0, s.intEn};
                end else if (regAddr == `PTM_SFR_PEND) begin
                    n.rdData = {3'h0, s.pend};
                end else begin
                    n.rdData = 8'h00;
                end
            end else if (ramOk(idx)) begin
                n.rdData = dmem[idx];
            end
        end

        // Current value for bit operations
        if (regAddr == `PTM_SFR_TBLP) begin
            src = s.tblp;
        end else if (regAddr == `PTM_SFR_TABLE_HIGH_BYTE) begin
            src = s.table_high_byte;
        end else if (regAddr == `PTM_SFR_BANK) begin
            src = {7'h00, s.bank};
        end else if (regAddr == `PTM_SFR_EDGE) begin
            src = {6'h00, s.edgeCfg};
        end else if (regAddr == `PTM_SFR_INTEN) begin
            src = {2'h0, s.intEn};
        end else if (regAddr >= `PTM_GP_START && ramOk(idx)) begin
            src = dmem[idx];
        end

        if (regWr) begin
            newVal = regWrData;
        end else if (bitSet) begin
            newVal = src | (8'h01 << bitSel);
        end else if (bitClr) begin
            newVal = src & ~(8'h01 << bitSel);
        end

        // Table read second cycle owns the write path
        if (s.phase == PTM_TBL) begin
            tword  = pmem[s.tblAddr];
            wrEn   = 1'b1;
            wrAddr = s.tblDest;
            wrBank = 1'b0;
            newVal = tword[7:0];
            n.table_high_byte = tword[15:8] & HI_MASK;
            n.phase = PTM_RUN;
        end else begin
            wrEn   = busOp;
            wrAddr = regAddr;
            wrBank = useB;
        end

        if (wrEn) begin
            if (wrAddr == `PTM_SFR_TBLP) begin
                n.tblp = newVal;
            end else if (wrAddr == `PTM_SFR_BANK) begin
                n.bank = newVal[0];
            end else if (wrAddr == `PTM_SFR_EDGE) begin
                n.edgeCfg = newVal[1:0];
            end else if (wrAddr == `PTM_SFR_INTEN) begin
                n.intEn = newVal[5:0];
            end else if (wrAddr >= `PTM_GP_START) begin
                ramIdx = ramSlot(wrAddr, wrBank);
                ramWe  = ramOk(ramIdx);
                ramWd  = newVal;
            end
            // Table high byte and pending flags are read-only here
        end

        // Fetch and sequencing
        n.fetchValid = 1'b1;
        n.fetchAddr  = s.pc;
        n.fetchWord  = pmem[s.pc];
        n.pc         = (s.pc + 13'h0001) & PC_MASK;

        if (s.phase == PTM_TBL) begin
            n.fetchValid = 1'b0;
            n.fetchAddr  = s.tblAddr;
            n.fetchWord  = 16'h0000;
            n.pc         = s.pc;
        end else if (tblReq) begin
            n.phase   = PTM_TBL;
            n.tblDest = tblDest;
            if (readTableCurrentPage) begin
                n.tblAddr = {s.pc[12:8], s.tblp} & PC_MASK;
            end else begin
                n.tblAddr = {`PTM_LAST_PAGE, s.tblp} & PC_MASK;
            end
        end else if (cmdJump) begin
            n.pc = cmdAddr & PC_MASK;
            n.fetchValid = 1'b0;
        end else if (cmdCall) begin
            if (s.sp < SP_FULL) begin
                n.stack[s.sp[2:0]] = s.pc;
                n.sp = s.sp + 4'h1;
            end
            n.pc = cmdAddr & PC_MASK;
            n.fetchValid = 1'b0;
        end else if (cmdReturn || cmdRetInt) begin
            if (s.sp != 4'h0) begin
                n.pc = s.stack[3'(s.sp - 4'h1)];
                n.sp = s.sp - 4'h1;
            end
            if (cmdRetInt) begin
                n.intEn[`PTM_INTEN_GLOBAL] = 1'b1;
            end
            n.fetchValid = 1'b0;
        end else if (s.intEn[`PTM_INTEN_GLOBAL] && live != 5'h00 && s.sp < SP_FULL) begin
            if (live[0]) begin
                ackMask = 5'h01;
                vec     = `PTM_EXT_VEC;
            end else if (live[1]) begin
                ackMask = 5'h02;
                vec     = `PTM_TMR0_VEC;
            end else if (live[2]) begin
                ackMask = 5'h04;
                vec     = `PTM_TMR1_VEC;
            end else if (live[3]) begin
                ackMask = 5'h08;
                vec     = `PTM_TMR2_VEC;
            end else begin
                ackMask = 5'h10;
                vec     = `PTM_TB_VEC;
            end
            n.stack[s.sp[2:0]] = s.pc;
            n.sp = s.sp + 4'h1;
            n.pc = vec & PC_MASK;
            n.intEn[`PTM_INTEN_GLOBAL] = 1'b0;
            n.fetchValid = 1'b0;
            n.vecTaken = 1'b1;
        end

        // New events win over the acknowledge clear
        n.pend = (s.pend & ~ackMask) | events;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.pc <= `PTM_RESET_VEC;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ramWe) begin
            dmem[ramIdx] <= ramWd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (progWr) begin
            pmem[progAddr & PC_MASK] <= progData & WORD_MASK;
        end
    end

    assign regRdData     = s.rdData;
    assign fetchAddr     = s.fetchAddr;
    assign fetchWord     = s.fetchWord;
    assign fetchValid    = s.fetchValid;
    assign tableBusy     = (s.phase == PTM_TBL);
    assign tableHighByte = s.table_high_byte;
    assign vectorTaken   = s.vecTaken;

endmodule : ptm_memory_map

// ===== verilog/ptm_pkg.sv
// Types of the program table and memory map block.
// Assumes the constants header is on the include path.
package ptm_pkg;

    typedef logic [12:0] ptm_pc_t;
    typedef logic [15:0] ptm_word_t;
    typedef logic [7:0]  ptm_byte_t;

    typedef enum logic {
        PTM_RUN,
        PTM_TBL
    } ptm_phase_t;

    typedef struct packed {
        ptm_phase_t       phase;
        ptm_pc_t          pc;
        logic [3:0]       sp;
        logic [7:0][12:0] stack;
        ptm_byte_t        tblp;
        ptm_byte_t        table_high_byte;
        logic             bank;
        logic [1:0]       edgeCfg;
        logic [5:0]       intEn;
        logic [4:0]       pend;
        logic             extS1;
        logic             extS2;
        logic             extPrev;
        ptm_pc_t          tblAddr;
        ptm_byte_t        tblDest;
        ptm_byte_t        rdData;
        ptm_pc_t          fetchAddr;
        ptm_word_t        fetchWord;
        logic             fetchValid;
        logic             vecTaken;
    } ptm_state_t;

endpackage : ptm_pkg
